// ---- slcr_pkg.sv ----
// constants shared by the synthesizer loop configuration register bank
package slcr_pkg;
    // register offsets on the serial control port
    localparam logic [7:0] OFS_NUM_HI = 8'h1B;
    localparam logic [7:0] OFS_NUM_MID = 8'h1C;
    localparam logic [7:0] OFS_NUM_LO = 8'h1D;
    localparam logic [7:0] OFS_MOD_CTRL = 8'h21;
    localparam logic [7:0] OFS_LOOP_A = 8'h22;
    localparam logic [7:0] OFS_LOOP_B = 8'h23;
    localparam logic [7:0] OFS_FILT_RES = 8'h24;
    // field positions
    localparam int DITHER_LSB = 2;
    localparam int ORDER_LSB = 0;
    localparam int DOUBLER_BIT = 5;
    localparam int RSVD_A_LSB = 6;
    localparam int PUMP_CUR_LSB = 0;
    localparam int PUMP_DLY_LSB = 4;
    localparam int THIRD_CAP_BIT = 2;
    localparam int NUM_HI_W = 6;
    localparam int NUM_W = 22;
    // reset values
    localparam logic [1:0] RST_DITHER = 2'h3;
    localparam logic [1:0] RST_ORDER = 2'h0;
    localparam logic RST_DOUBLER = 1'b1;
    localparam logic [1:0] RST_RSVD_A = 2'h0;
    localparam logic [3:0] RST_PUMP_CUR = 4'h8;
    localparam logic [2:0] RST_PUMP_DLY = 3'h0;
    localparam logic RST_THIRD_CAP = 1'b0;
    localparam logic [1:0] RSVD_B_LOW = 2'h3;
    localparam logic [7:0] RST_FILT_RES = 8'h08;
    localparam logic [21:0] RST_NUM = 22'h000000;
    // legal codes
    localparam logic [1:0] DITHER_WEAK = 2'h0;
    localparam logic [1:0] DITHER_OFF = 2'h3;
    localparam logic [1:0] ORDER_INT = 2'h0;
    localparam logic [1:0] ORDER_THIRD = 2'h3;
    localparam logic [3:0] PUMP_1P6MA = 4'h4;
    localparam logic [3:0] PUMP_6P4MA = 4'h8;
endpackage : slcr_pkg

// ---- slcr_regs.sv ----
// What this block does
// R1 - dither field bits 3:2, reset three
// R2 - modulator order bits 1:0, reset zero
// R3 - doubler enable bit 5, reset one
// R4 - pump current bits 3:0, reset eight
// R5 - pump delay bits 6:4, reset zero
// R6 - third capacitor enable bit 2, reset zero
// R7 - filter resistor code byte, reset 0x08
// R8 - 22-bit numerator from three byte registers
// R9 - nonvolatile copy loads fields after power-up
`timescale 1ns/10ps
`default_nettype none
module slcr_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic nvm_load,
    input wire logic [7:0] nvm_mod_ctrl,
    input wire logic [7:0] nvm_loop_a,
    input wire logic [7:0] nvm_loop_b,
    input wire logic [7:0] nvm_filt_res,
    input wire logic [21:0] nvm_num,
    output logic [7:0] rd_data_ff,
    output logic rd_valid_ff,
    output logic [1:0] dither_select_ff,
    output logic [1:0] order_ff,
    output logic doubler_en_ff,
    output logic [3:0] pump_current_code_ff,
    output logic [2:0] pump_delay_code_ff,
    output logic third_cap_en_ff,
    output logic [7:0] filter_res_code_ff,
    output logic [21:0] frac_numerator_ff,
    output logic reserved_code_ff
);
    // storage of the writable fields
    logic [1:0] rsvd_a_ff; // reserved bits 7:6 of loop_control_a, kept as written
    logic [21:0] num_ff; // raw numerator, held even in integer mode
    logic [1:0] nxt_dither;
    logic [1:0] nxt_order;
    logic nxt_doubler;
    logic [1:0] nxt_rsvd_a;
    logic [3:0] nxt_pump_cur;
    logic [2:0] nxt_pump_dly;
    logic nxt_third_cap;
    logic [7:0] nxt_filt_res;
    logic [21:0] nxt_num;
    logic [21:0] nxt_frac_num;
    logic nxt_reserved;
    logic [7:0] nxt_rd_data;
    logic nxt_rd_valid;
    logic wr_mod; // decoded write strobes
    logic wr_a;
    logic wr_b;
    logic wr_r;
    logic wr_nh;
    logic wr_nm;
    logic wr_nl;

    // read view of each register, reserved bits as the map defines them
    function automatic logic [7:0] reg_view(input logic [7:0] addr, input logic [1:0] dth,
            input logic [1:0] ord, input logic dbl, input logic [1:0] rsa, input logic [3:0] cur,
            input logic [2:0] dly, input logic c3, input logic [7:0] res, input logic [21:0] num);
        case (addr)
            slcr_pkg::OFS_MOD_CTRL: reg_view = {4'h0, dth, ord};
            slcr_pkg::OFS_LOOP_A: reg_view = {rsa, dbl, 1'b0, cur};
            slcr_pkg::OFS_LOOP_B: reg_view = {1'b0, dly, 1'b0, c3, slcr_pkg::RSVD_B_LOW};
            slcr_pkg::OFS_FILT_RES: reg_view = res;
            slcr_pkg::OFS_NUM_HI: reg_view = {2'h0, num[21:16]};
            slcr_pkg::OFS_NUM_MID: reg_view = num[15:8];
            slcr_pkg::OFS_NUM_LO: reg_view = num[7:0];
            default: reg_view = 8'h00; // unmapped offsets read as zero
        endcase
    endfunction : reg_view

    // write decode; writes to unmapped offsets are dropped
    always_comb begin
        wr_mod = reg_wr && (reg_addr == slcr_pkg::OFS_MOD_CTRL);
        wr_a = reg_wr && (reg_addr == slcr_pkg::OFS_LOOP_A);
        wr_b = reg_wr && (reg_addr == slcr_pkg::OFS_LOOP_B);
        wr_r = reg_wr && (reg_addr == slcr_pkg::OFS_FILT_RES);
        wr_nh = reg_wr && (reg_addr == slcr_pkg::OFS_NUM_HI);
        wr_nm = reg_wr && (reg_addr == slcr_pkg::OFS_NUM_MID);
        wr_nl = reg_wr && (reg_addr == slcr_pkg::OFS_NUM_LO);
    end

    // next field values: nonvolatile load first, a serial write in the same cycle wins
    always_comb begin
        nxt_dither = dither_select_ff;
        nxt_order = order_ff;
        nxt_doubler = doubler_en_ff;
        nxt_rsvd_a = rsvd_a_ff;
        nxt_pump_cur = pump_current_code_ff;
        nxt_pump_dly = pump_delay_code_ff;
        nxt_third_cap = third_cap_en_ff;
        nxt_filt_res = filter_res_code_ff;
        nxt_num = num_ff;
        if (nvm_load) begin // [R9]
            nxt_dither = nvm_mod_ctrl[slcr_pkg::DITHER_LSB +: 2];
            nxt_order = nvm_mod_ctrl[slcr_pkg::ORDER_LSB +: 2];
            nxt_doubler = nvm_loop_a[slcr_pkg::DOUBLER_BIT];
            nxt_rsvd_a = nvm_loop_a[slcr_pkg::RSVD_A_LSB +: 2];
            nxt_pump_cur = nvm_loop_a[slcr_pkg::PUMP_CUR_LSB +: 4];
            nxt_pump_dly = nvm_loop_b[slcr_pkg::PUMP_DLY_LSB +: 3];
            nxt_third_cap = nvm_loop_b[slcr_pkg::THIRD_CAP_BIT];
            nxt_filt_res = nvm_filt_res;
            nxt_num = nvm_num;
        end
        if (wr_mod) begin
            nxt_dither = reg_wdata[slcr_pkg::DITHER_LSB +: 2]; // [R1]
            nxt_order = reg_wdata[slcr_pkg::ORDER_LSB +: 2]; // [R2]
        end
        if (wr_a) begin
            nxt_doubler = reg_wdata[slcr_pkg::DOUBLER_BIT]; // [R3]
            nxt_rsvd_a = reg_wdata[slcr_pkg::RSVD_A_LSB +: 2];
            nxt_pump_cur = reg_wdata[slcr_pkg::PUMP_CUR_LSB +: 4]; // [R4]
        end
        if (wr_b) begin
            // bits 1:0 are fixed reserved ones, only the two fields store
            nxt_pump_dly = reg_wdata[slcr_pkg::PUMP_DLY_LSB +: 3]; // [R5]
            nxt_third_cap = reg_wdata[slcr_pkg::THIRD_CAP_BIT]; // [R6]
        end
        if (wr_r) begin
            nxt_filt_res = reg_wdata; // [R7]
        end
        // each byte lands in its own slice of the numerator
        if (wr_nh) begin
            nxt_num[21:16] = reg_wdata[slcr_pkg::NUM_HI_W-1:0]; // [R8]
        end
        if (wr_nm) begin
            nxt_num[15:8] = reg_wdata; // [R8]
        end
        if (wr_nl) begin
            nxt_num[7:0] = reg_wdata; // [R8]
        end
        // numerator only reaches the modulator in third-order mode
        nxt_frac_num = (nxt_order == slcr_pkg::ORDER_THIRD) ? nxt_num : slcr_pkg::RST_NUM; // [R8]
        // reserved codes are stored as written but flagged for software
        nxt_reserved = (nxt_dither != slcr_pkg::DITHER_WEAK && nxt_dither != slcr_pkg::DITHER_OFF)
            || (nxt_order != slcr_pkg::ORDER_INT && nxt_order != slcr_pkg::ORDER_THIRD)
            || (nxt_pump_cur != slcr_pkg::PUMP_1P6MA && nxt_pump_cur != slcr_pkg::PUMP_6P4MA); // [R4]
    end

    // read path: data one cycle after the strobe
    always_comb begin
        nxt_rd_valid = reg_rd;
        nxt_rd_data = reg_rd ? reg_view(reg_addr, dither_select_ff, order_ff, doubler_en_ff, rsvd_a_ff,
            pump_current_code_ff, pump_delay_code_ff, third_cap_en_ff, filter_res_code_ff, num_ff)
            : rd_data_ff;
    end

    // registers; reset values hold until the nonvolatile image loads or a serial write changes them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dither_select_ff <= slcr_pkg::RST_DITHER; // [R1]
            order_ff <= slcr_pkg::RST_ORDER; // [R2]
            doubler_en_ff <= slcr_pkg::RST_DOUBLER; // [R3]
            rsvd_a_ff <= slcr_pkg::RST_RSVD_A;
            pump_current_code_ff <= slcr_pkg::RST_PUMP_CUR; // [R4]
            pump_delay_code_ff <= slcr_pkg::RST_PUMP_DLY; // [R5]
            third_cap_en_ff <= slcr_pkg::RST_THIRD_CAP; // [R6]
            filter_res_code_ff <= slcr_pkg::RST_FILT_RES; // [R7]
            num_ff <= slcr_pkg::RST_NUM;
            frac_numerator_ff <= slcr_pkg::RST_NUM;
            reserved_code_ff <= 1'b0;
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            dither_select_ff <= nxt_dither;
            order_ff <= nxt_order;
            doubler_en_ff <= nxt_doubler;
            rsvd_a_ff <= nxt_rsvd_a;
            pump_current_code_ff <= nxt_pump_cur;
            pump_delay_code_ff <= nxt_pump_dly;
            third_cap_en_ff <= nxt_third_cap;
            filter_res_code_ff <= nxt_filt_res;
            num_ff <= nxt_num;
            frac_numerator_ff <= nxt_frac_num;
            reserved_code_ff <= nxt_reserved;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // checks beside the logic
    chk_dither_write: assert property (@(posedge clock) disable iff (rst) // [R1]
        wr_mod |=> dither_select_ff == $past(reg_wdata[3:2])) else $error("dither write lost");
    chk_order_write: assert property (@(posedge clock) disable iff (rst) // [R2]
        wr_mod |=> order_ff == $past(reg_wdata[1:0])) else $error("order write lost");
    chk_doubler_write: assert property (@(posedge clock) disable iff (rst) // [R3]
        wr_a |=> doubler_en_ff == $past(reg_wdata[5])) else $error("doubler write lost");
    chk_pump_write: assert property (@(posedge clock) disable iff (rst) // [R4]
        wr_a |=> pump_current_code_ff == $past(reg_wdata[3:0])) else $error("pump current write lost");
    chk_cap_write: assert property (@(posedge clock) disable iff (rst) // [R6]
        wr_b |=> third_cap_en_ff == $past(reg_wdata[2])) else $error("third cap write lost");
    chk_resistor_write: assert property (@(posedge clock) disable iff (rst) // [R7]
        wr_r |=> filter_res_code_ff == $past(reg_wdata)) else $error("resistor write lost");
    chk_num_low_write: assert property (@(posedge clock) disable iff (rst) // [R8]
        wr_nl |=> num_ff[7:0] == $past(reg_wdata)) else $error("numerator low byte write lost");
    chk_doubler_hold: assert property (@(posedge clock) disable iff (rst) // [R3]
        !wr_a && !nvm_load |=> $stable(doubler_en_ff)) else $error("doubler changed unasked");
    chk_pump_flag: assert property (@(posedge clock) disable iff (rst) // [R4]
        wr_a && reg_wdata[3:0] != 4'h4 && reg_wdata[3:0] != 4'h8 |=> reserved_code_ff)
        else $error("reserved pump code not flagged");
    chk_delay_write: assert property (@(posedge clock) disable iff (rst) // [R5]
        wr_b |=> pump_delay_code_ff == $past(reg_wdata[6:4])) else $error("pump delay write lost");
    chk_loopb_read: assert property (@(posedge clock) disable iff (rst) // [R6]
        reg_rd && reg_addr == 8'h23 |=> rd_valid_ff && rd_data_ff[2] == $past(third_cap_en_ff)
        && rd_data_ff[1:0] == 2'h3) else $error("loop_control_b read wrong");
    chk_resistor_reset: assert property (@(posedge clock) // [R7]
        rst |=> filter_res_code_ff == 8'h08 || !$past(rst) || !rst) else $error("resistor reset wrong");
    chk_num_gate: assert property (@(posedge clock) disable iff (rst) // [R8]
        order_ff != 2'h3 |-> frac_numerator_ff == 22'h000000) else $error("numerator leaked in integer mode");
    chk_nvm_load: assert property (@(posedge clock) disable iff (rst) // [R9]
        nvm_load && !reg_wr |=> filter_res_code_ff == $past(nvm_filt_res) ##1 $stable(filter_res_code_ff)
        || $past(reg_wr) || $past(nvm_load)) else $error("nonvolatile load missed");
    cov_third_order: cover property (@(posedge clock) disable iff (rst) wr_mod ##1 order_ff == 2'h3);
    cov_nvm_then_write: cover property (@(posedge clock) disable iff (rst) nvm_load ##[1:4] wr_r);
    cov_num_bytes: cover property (@(posedge clock) disable iff (rst) wr_nh ##[1:3] wr_nm ##[1:3] wr_nl);
    // strobes from the bench are spaced two cycles apart, so the read may trail by a few cycles
    cov_read_back: cover property (@(posedge clock) disable iff (rst) wr_a ##[1:4] reg_rd && reg_addr == 8'h22);
endmodule : slcr_regs
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nvm_load = 1'b0;
    logic [7:0] nvm_mod_ctrl = 8'h00;
    logic [7:0] nvm_loop_a = 8'h00;
    logic [7:0] nvm_loop_b = 8'h00;
    logic [7:0] nvm_filt_res = 8'h00;
    logic [21:0] nvm_num = 22'h000000;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    logic [1:0] dither_select_ff;
    logic [1:0] order_ff;
    logic doubler_en_ff;
    logic [3:0] pump_current_code_ff;
    logic [2:0] pump_delay_code_ff;
    logic third_cap_en_ff;
    logic [7:0] filter_res_code_ff;
    logic [21:0] frac_numerator_ff;
    logic reserved_code_ff;
    int fails = 0;
    int cmp_count = 0;
    int seed_val;
    // shadow copy of the four control bytes and the numerator
    logic [7:0] m_mod, m_a, m_b, m_r;
    logic [21:0] m_num;
    logic [7:0] res_tbl [8] = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h30, 8'h40, 8'hFF, 8'h00};
    logic [7:0] adr_tbl [8] = '{8'h1B, 8'h1C, 8'h1D, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};

    // free-running 50 MHz clock
    always #10 clock = ~clock;

    slcr_regs u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .nvm_load(nvm_load), .nvm_mod_ctrl(nvm_mod_ctrl), .nvm_loop_a(nvm_loop_a),
        .nvm_loop_b(nvm_loop_b), .nvm_filt_res(nvm_filt_res), .nvm_num(nvm_num), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .dither_select_ff(dither_select_ff), .order_ff(order_ff),
        .doubler_en_ff(doubler_en_ff), .pump_current_code_ff(pump_current_code_ff),
        .pump_delay_code_ff(pump_delay_code_ff), .third_cap_en_ff(third_cap_en_ff),
        .filter_res_code_ff(filter_res_code_ff), .frac_numerator_ff(frac_numerator_ff),
        .reserved_code_ff(reserved_code_ff));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // reset image; bits 1:0 of loop_b always read back as ones
    function automatic void model_reset();
        m_mod = 8'h0C;
        m_a = 8'h28;
        m_b = 8'h03;
        m_r = 8'h08;
        m_num = 22'h000000;
    endfunction : model_reset

    // unmapped offsets fall through and change nothing
    function automatic void model_wr(input logic [7:0] a, input logic [7:0] d);
        case (a)
            slcr_pkg::OFS_MOD_CTRL: m_mod = d & 8'h0F;
            slcr_pkg::OFS_LOOP_A: m_a = d & 8'hEF;
            slcr_pkg::OFS_LOOP_B: m_b = (d & 8'h74) | 8'h03;
            slcr_pkg::OFS_FILT_RES: m_r = d;
            slcr_pkg::OFS_NUM_HI: m_num[21:16] = d[5:0];
            slcr_pkg::OFS_NUM_MID: m_num[15:8] = d;
            slcr_pkg::OFS_NUM_LO: m_num[7:0] = d;
            default: ;
        endcase
    endfunction : model_wr

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            slcr_pkg::OFS_MOD_CTRL: return m_mod;
            slcr_pkg::OFS_LOOP_A: return m_a;
            slcr_pkg::OFS_LOOP_B: return m_b;
            slcr_pkg::OFS_FILT_RES: return m_r;
            slcr_pkg::OFS_NUM_HI: return {2'h0, m_num[21:16]};
            slcr_pkg::OFS_NUM_MID: return m_num[15:8];
            slcr_pkg::OFS_NUM_LO: return m_num[7:0];
            default: return 8'h00;
        endcase
    endfunction : exp_rd

    // reserved dither, order or pump codes raise the flag
    function automatic logic exp_rsvd();
        return (m_mod[3:2] inside {2'h1, 2'h2}) || (m_mod[1:0] inside {2'h1, 2'h2})
            || !(m_a[3:0] inside {4'h4, 4'h8});
    endfunction : exp_rsvd

    task automatic check_fields();
        chk(32'(dither_select_ff), 32'(m_mod[3:2]));
        chk(32'(order_ff), 32'(m_mod[1:0]));
        chk(32'(doubler_en_ff), 32'(m_a[5]));
        chk(32'(pump_current_code_ff), 32'(m_a[3:0]));
        chk(32'(pump_delay_code_ff), 32'(m_b[6:4]));
        chk(32'(third_cap_en_ff), 32'(m_b[2]));
        chk(32'(filter_res_code_ff), 32'(m_r));
        chk(32'(frac_numerator_ff), 32'((m_mod[1:0] == 2'h3) ? m_num : 22'h0));
        chk(32'(reserved_code_ff), 32'(exp_rsvd()));
    endtask : check_fields

    // one strobe cycle; a read in the same cycle as a write sees the old value
    task automatic op(input logic w, input logic r, input logic ld, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] exp;
        exp = exp_rd(a);
        @(negedge clock);
        reg_wr = w;
        reg_rd = r;
        nvm_load = ld;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        nvm_load = 1'b0;
        // image first, then the write overrides what it touches
        if (ld) begin
            m_mod = nvm_mod_ctrl & 8'h0F;
            m_a = nvm_loop_a & 8'hEF;
            m_b = (nvm_loop_b & 8'h74) | 8'h03;
            m_r = nvm_filt_res;
            m_num = nvm_num;
        end
        if (w) model_wr(a, d);
        chk(32'(rd_valid_ff), 32'(r));
        if (r) chk(32'(rd_data_ff), 32'(exp));
        check_fields();
    endtask : op

    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        stop_test();
    end

    initial begin
        seed_val = $urandom(32'h182F2339);
        model_reset();
        repeat (5) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        check_fields();
        chk(32'(rd_data_ff), 32'h0);
        for (int i = 0; i < 8; i++) op(1'b0, 1'b1, 1'b0, adr_tbl[i], 8'h00);
        // every dither/order pair, legal and reserved
        for (int i = 0; i < 16; i++) op(1'b1, 1'b1, 1'b0, slcr_pkg::OFS_MOD_CTRL, 8'(i) | 8'hF0);
        for (int i = 0; i < 16; i++) op(1'b1, 1'b1, 1'b0, slcr_pkg::OFS_LOOP_A, 8'(i) | 8'($urandom) & 8'hF0);
        for (int i = 0; i < 16; i++) begin
            op(1'b1, 1'b1, 1'b0, slcr_pkg::OFS_LOOP_B, {1'b1, 3'(i), 1'b1, i[3], 2'h0});
        end
        foreach (res_tbl[i]) op(1'b1, 1'b1, 1'b0, slcr_pkg::OFS_FILT_RES, res_tbl[i]);
        // numerator only shows in third-order mode
        op(1'b1, 1'b0, 1'b0, slcr_pkg::OFS_MOD_CTRL, 8'h03);
        for (int i = 0; i < 3; i++) op(1'b1, 1'b1, 1'b0, adr_tbl[i], 8'hFF);
        op(1'b1, 1'b0, 1'b0, slcr_pkg::OFS_MOD_CTRL, 8'h00);
        // nonvolatile image, then load and write colliding
        for (int i = 0; i < 8; i++) begin
            nvm_mod_ctrl = 8'($urandom);
            nvm_loop_a = 8'($urandom);
            nvm_loop_b = 8'($urandom);
            nvm_filt_res = 8'($urandom);
            nvm_num = 22'($urandom);
            op(i[0], 1'b0, 1'b1, adr_tbl[i], 8'($urandom));
        end
        repeat (300) op(1'($urandom), 1'($urandom), 1'b0, adr_tbl[$urandom % 8], 8'($urandom));
        // second reset in mid-run restores the reset image
        @(negedge clock) rst = 1'b1;
        @(negedge clock) rst = 1'b0;
        model_reset();
        for (int i = 0; i < 8; i++) op(1'b0, 1'b1, 1'b0, adr_tbl[i], 8'h00);
        stop_test();
    end
endmodule : tb
`default_nettype wire
